// file: src/gst_pkg.sv
// package: constants for the gated sixteen bit timer
package gst_pkg;
   // register offsets on the plain register port
   localparam logic [2:0] ADDR_COUNT_LOW = 3'h0; // count_low_byte
   localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1; // count_high_byte (or buffer)
   localparam logic [2:0] ADDR_TIMER_CTRL = 3'h2; // timer_control_reg
   localparam logic [2:0] ADDR_GATE_CTRL = 3'h3; // gate_control_reg
   localparam logic [2:0] ADDR_STATUS = 3'h4; // overflow flag, write 1 to clear
   // timer_control_reg fields
   localparam int CS_MSB = 7; // clock_source_select
   localparam int CS_LSB = 6;
   localparam int PS_MSB = 5; // prescale_select
   localparam int PS_LSB = 4;
   localparam int OSC_BIT = 3; // secondary_osc_request
   localparam int SYNC_BIT = 2; // sync_disable_bit
   localparam int WIDE_BIT = 1; // wide_access_enable
   localparam int ON_BIT = 0; // timer_on_bit
   // gate_control_reg fields
   localparam int GE_BIT = 7; // gate_enable_bit
   localparam int GPOL_BIT = 6; // gate_polarity
   localparam int GTM_BIT = 5; // gate_toggle_enable
   localparam int GSS_MSB = 1; // gate_source_select
   localparam int GSS_LSB = 0;
   // writable masks and reset values
   localparam logic [7:0] TIMER_CTRL_MASK = 8'hff;
   localparam logic [7:0] GATE_CTRL_MASK = 8'he3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [7:0] COMPANION_MAX = 8'hff;
   // instruction clock divides system clock by four
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   // clock source encodings
   typedef enum logic [1:0] {
      GST_CS_INSTR = 2'b00,
      GST_CS_SYS = 2'b01,
      GST_CS_EXT = 2'b10,
      GST_CS_LFOSC = 2'b11
   } gst_cs_type;
   // gate source encodings
   typedef enum logic [1:0] {
      GST_GS_PIN = 2'b00,
      GST_GS_COMPANION = 2'b01,
      GST_GS_CMP1 = 2'b10,
      GST_GS_CMP2 = 2'b11
   } gst_gs_type;
endpackage

// file: src/gst_timer.sv
// module: gated sixteen bit timer with prescaler, wide access and gate logic
`timescale 1ns/10ps
`default_nettype none
module gst_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic external_count_input,
   input wire logic gate_input_pin,
   input wire logic low_freq_internal_osc,
   input wire logic crystal_in_pin,
   output logic crystal_out_pin,
   output logic secondary_osc_enable,
   input wire logic companion_8bit_timer_tick,
   input wire logic [7:0] companion_8bit_timer,
   input wire logic cmp1_out,
   input wire logic cmp2_out,
   input wire logic cmp_gate_sync,
   output logic overflow_flag,
   output logic [15:0] count_value
);
   // control registers
   logic [7:0] timer_control_reg; // timer_control_reg image
   logic [7:0] gate_control_reg; // gate_control_reg image
   logic [15:0] count_reg; // live count
   logic [7:0] high_buf_reg; // wide access buffer
   logic [2:0] presc_reg; // prescale counter
   logic [1:0] instr_div_reg; // divide by four for instruction clock
   logic ovf_reg; // sticky overflow flag
   logic gate_ff_reg; // toggle flip-flop
   logic armed_reg; // falling edge seen on event input
   logic [7:0] rdata_reg; // read data register
   logic xtal_reg; // crystal amplifier output
   logic cmp_pulse_reg; // companion wrap pulse
   logic [7:0] comp_prev_reg; // previous companion count
   // two stage synchronisers
   logic [1:0] ext_sync1_reg, ext_sync2_reg; // external / crystal input
   logic [1:0] lf_sync_reg; // low frequency oscillator
   logic [1:0] gpin_sync_reg; // gate pin
   logic [1:0] c1_sync_reg; // comparator 1
   logic [1:0] c2_sync_reg; // comparator 2
   logic ext_prev_reg; // previous external level
   logic lf_prev_reg; // previous low osc level
   logic gate_prev_reg; // previous selected gate level
   logic ext_fast_reg; // single stage capture for async mode
   logic ext_fast_prev_reg; // previous fast capture

   // decoded controls
   logic timer_on, gate_en, gate_pol, gate_tm, sync_dis, wide_mode;
   logic [1:0] presc_sel;
   gst_pkg::gst_cs_type cs_sel;
   gst_pkg::gst_gs_type gs_sel;
   assign timer_on = timer_control_reg[gst_pkg::ON_BIT];
   assign wide_mode = timer_control_reg[gst_pkg::WIDE_BIT];
   assign sync_dis = timer_control_reg[gst_pkg::SYNC_BIT];
   assign presc_sel = timer_control_reg[gst_pkg::PS_MSB:gst_pkg::PS_LSB];
   assign cs_sel = gst_pkg::gst_cs_type'(timer_control_reg[gst_pkg::CS_MSB:gst_pkg::CS_LSB]);
   assign gate_en = gate_control_reg[gst_pkg::GE_BIT];
   assign gate_pol = gate_control_reg[gst_pkg::GPOL_BIT];
   assign gate_tm = gate_control_reg[gst_pkg::GTM_BIT];
   assign gs_sel = gst_pkg::gst_gs_type'(gate_control_reg[gst_pkg::GSS_MSB:gst_pkg::GSS_LSB]);

   // address decode helper
   function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] t);
      hit = strobe && (a == t);
   endfunction

   // write and read decodes
   logic wr_low, wr_high, rd_low, count_write, presc_clear;
   assign wr_low = hit(reg_wr, reg_addr, gst_pkg::ADDR_COUNT_LOW);
   assign wr_high = hit(reg_wr, reg_addr, gst_pkg::ADDR_COUNT_HIGH);
   assign rd_low = hit(reg_rd, reg_addr, gst_pkg::ADDR_COUNT_LOW);
   assign count_write = wr_low || wr_high;
   assign presc_clear = wr_low || (wr_high && !wide_mode);
   // writes that reach the live count; a buffered high write does not
   logic count_load;
   assign count_load = wr_low || (wr_high && !wide_mode);

   // synchronisers: first stage read only by second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_sync1_reg <= 2'h0;
         lf_sync_reg <= 2'h0;
         gpin_sync_reg <= 2'h0;
         c1_sync_reg <= 2'h0;
         c2_sync_reg <= 2'h0;
      end else begin
         // secondary oscillator replaces the pin when requested
         ext_sync1_reg <= {ext_sync1_reg[0],
            timer_control_reg[gst_pkg::OSC_BIT] ? crystal_in_pin : external_count_input};
         lf_sync_reg <= {lf_sync_reg[0], low_freq_internal_osc};
         gpin_sync_reg <= {gpin_sync_reg[0], gate_input_pin};
         c1_sync_reg <= {c1_sync_reg[0], cmp1_out};
         c2_sync_reg <= {c2_sync_reg[0], cmp2_out};
      end
   end

   // extra stage for synchronous mode, one stage less when sync disabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_sync2_reg <= 2'h0;
         ext_prev_reg <= 1'b0;
         lf_prev_reg <= 1'b0;
         ext_fast_reg <= 1'b0;
         ext_fast_prev_reg <= 1'b0;
      end else begin
         ext_sync2_reg <= {ext_sync2_reg[0], ext_sync1_reg[1]};
         ext_prev_reg <= ext_sync2_reg[1];
         lf_prev_reg <= lf_sync_reg[1];
         ext_fast_reg <= ext_sync1_reg[1]; // shortest legal path
         ext_fast_prev_reg <= ext_fast_reg;
      end
   end

   // external level and edges in the chosen path
   logic ext_level, ext_rise, ext_fall;
   // async mode skips the extra resync stage, so a mode switch may
   // drop or add one edge
   assign ext_level = sync_dis ? ext_fast_reg : ext_sync2_reg[1];
   assign ext_rise = sync_dis ? (ext_fast_reg && !ext_fast_prev_reg)
                              : (ext_sync2_reg[1] && !ext_prev_reg);
   assign ext_fall = sync_dis ? (!ext_fast_reg && ext_fast_prev_reg)
                              : (!ext_sync2_reg[1] && ext_prev_reg);

   // instruction clock divider, free running
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instr_div_reg <= 2'h0;
      end else begin
         instr_div_reg <= instr_div_reg + 2'h1;
      end
   end

   // falling edge arming for event counting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed_reg <= 1'b0;
      end else if (!timer_on || count_write) begin
         armed_reg <= 1'b0; // disabled or written: rearm
      end else if (ext_fall) begin
         armed_reg <= 1'b1;
      end
   end

   // raw tick of the selected source
   logic src_tick;
   always_comb begin
      case (cs_sel)
         gst_pkg::GST_CS_INSTR: src_tick = (instr_div_reg == gst_pkg::INSTR_DIV_LAST);
         gst_pkg::GST_CS_SYS: src_tick = 1'b1;
         gst_pkg::GST_CS_EXT: src_tick = ext_rise && armed_reg;
         gst_pkg::GST_CS_LFOSC: src_tick = lf_sync_reg[1] && !lf_prev_reg;
         default: src_tick = 1'b0;
      endcase
   end

   // companion wrap detector: one cycle pulse on FFh to 00h
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         comp_prev_reg <= 8'h00;
         cmp_pulse_reg <= 1'b0;
      end else begin
         comp_prev_reg <= companion_8bit_timer;
         cmp_pulse_reg <= companion_8bit_timer_tick
            && (comp_prev_reg == gst_pkg::COMPANION_MAX)
            && (companion_8bit_timer == 8'h00);
      end
   end

   // gate source mux
   logic gate_src;
   always_comb begin
      case (gs_sel)
         gst_pkg::GST_GS_PIN: gate_src = gpin_sync_reg[1];
         gst_pkg::GST_GS_COMPANION: gate_src = cmp_pulse_reg;
         // comparators synchronised or taken directly
         gst_pkg::GST_GS_CMP1: gate_src = cmp_gate_sync ? c1_sync_reg[1] : cmp1_out;
         gst_pkg::GST_GS_CMP2: gate_src = cmp_gate_sync ? c2_sync_reg[1] : cmp2_out;
         default: gate_src = 1'b0;
      endcase
   end

   // polarity applied gate level
   logic gate_lvl;
   assign gate_lvl = gate_src ~^ gate_pol; // count when gate equals polarity

   // toggle flip-flop on rising edge of the active gate level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate_prev_reg <= 1'b0;
         gate_ff_reg <= 1'b0;
      end else begin
         gate_prev_reg <= gate_lvl;
         if (!timer_on || !gate_tm) begin
            gate_ff_reg <= 1'b0;
         end else if (gate_lvl && !gate_prev_reg) begin
            gate_ff_reg <= !gate_ff_reg;
         end
      end
   end

   // count permission
   logic gate_ok, count_ok;
   assign gate_ok = gate_tm ? gate_ff_reg : gate_lvl;
   assign count_ok = timer_on && (!gate_en || gate_ok);

   // prescaler terminal value per selection
   logic [2:0] presc_last;
   always_comb begin
      case (presc_sel)
         2'b00: presc_last = 3'h0;
         2'b01: presc_last = 3'h1;
         2'b10: presc_last = 3'h3;
         2'b11: presc_last = 3'h7;
         default: presc_last = 3'h0;
      endcase
   end

   // increment strobe
   logic inc;
   assign inc = count_ok && src_tick && (presc_reg == presc_last) && !count_load;

   // prescaler counter, not visible to software
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         presc_reg <= 3'h0;
      end else if (presc_clear) begin
         presc_reg <= 3'h0;
      end else if (count_ok && src_tick) begin
         presc_reg <= (presc_reg == presc_last) ? 3'h0 : presc_reg + 3'h1;
      end
   end

   // live count; writes win over increments
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= gst_pkg::COUNT_RESET;
      end else if (wr_low) begin
         // wide mode: high byte loaded from the buffer
         count_reg <= {(wide_mode ? high_buf_reg : count_reg[15:8]), reg_wdata};
      end else if (wr_high && !wide_mode) begin
         count_reg[15:8] <= reg_wdata;
      end else if (inc) begin
         count_reg <= count_reg + 16'h0001; // wraps to 0000h
      end
   end

   // high byte buffer for wide access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_buf_reg <= 8'h00;
      end else if (wide_mode && wr_high) begin
         high_buf_reg <= reg_wdata;
      end else if (wide_mode && rd_low) begin
         high_buf_reg <= count_reg[15:8];
      end
   end

   // overflow flag: set wins over software clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ovf_reg <= 1'b0;
      end else if (inc && (count_reg == gst_pkg::COUNT_MAX)) begin
         ovf_reg <= 1'b1;
      end else if (hit(reg_wr, reg_addr, gst_pkg::ADDR_STATUS) && reg_wdata[0]) begin
         ovf_reg <= 1'b0;
      end
   end

   // control register writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timer_control_reg <= gst_pkg::CTRL_RESET;
         gate_control_reg <= gst_pkg::CTRL_RESET;
      end else begin
         if (hit(reg_wr, reg_addr, gst_pkg::ADDR_TIMER_CTRL)) begin
            timer_control_reg <= reg_wdata & gst_pkg::TIMER_CTRL_MASK;
         end
         if (hit(reg_wr, reg_addr, gst_pkg::ADDR_GATE_CTRL)) begin
            gate_control_reg <= reg_wdata & gst_pkg::GATE_CTRL_MASK;
         end
      end
   end

   // read data, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            gst_pkg::ADDR_COUNT_LOW: rdata_reg <= count_reg[7:0];
            gst_pkg::ADDR_COUNT_HIGH: begin
               // wide mode reads the buffer, otherwise the live byte
               rdata_reg <= wide_mode ? high_buf_reg : count_reg[15:8];
            end
            gst_pkg::ADDR_TIMER_CTRL: rdata_reg <= timer_control_reg;
            gst_pkg::ADDR_GATE_CTRL: rdata_reg <= gate_control_reg;
            gst_pkg::ADDR_STATUS: rdata_reg <= {7'h00, ovf_reg};
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // crystal amplifier: inverts input while enabled, runs regardless of gate
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xtal_reg <= 1'b0;
      end else begin
         xtal_reg <= timer_control_reg[gst_pkg::OSC_BIT] && !ext_sync1_reg[1];
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata = rdata_reg;
   assign overflow_flag = ovf_reg;
   assign count_value = count_reg;
   assign crystal_out_pin = xtal_reg;
   assign secondary_osc_enable = timer_control_reg[gst_pkg::OSC_BIT];
endmodule // gst_timer
`default_nettype wire

// file: tb/gated_sixteen_bit_timer_tb.sv
// testbench: self checking bench for the gated timer
`timescale 1ns/10ps
`default_nettype none
module gated_sixteen_bit_timer_tb;
   localparam logic [2:0] A_LO = gst_pkg::ADDR_COUNT_LOW;
   localparam logic [2:0] A_HI = gst_pkg::ADDR_COUNT_HIGH;
   localparam logic [2:0] A_TC = gst_pkg::ADDR_TIMER_CTRL;
   localparam logic [2:0] A_GC = gst_pkg::ADDR_GATE_CTRL;
   localparam logic [2:0] A_ST = gst_pkg::ADDR_STATUS;
   logic clk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext_run = 1'b1, ext_level = 1'b0;
   logic gate_level = 1'b0, cmp1 = 1'b0, cmp2 = 1'b0, cmp_sync = 1'b0;
   logic ext, lf, xtal, gpin, tick, osc_en, ovf, xout;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, gate_per = 8'h00, reg_rdata, comp;
   logic [15:0] cnt;
   int errors = 0, num_checks = 0, seed = 59;
   gst_far_side far (.clk(clk), .rst(rst), .ext_run(ext_run), .ext_level(ext_level),
      .gate_per(gate_per), .gate_level(gate_level), .ext_pin(ext), .lf_osc(lf),
      .xtal(xtal), .gate_pin(gpin), .tick(tick), .comp_cnt(comp));
   gst_timer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_count_input(ext), .gate_input_pin(gpin), .low_freq_internal_osc(lf),
      .crystal_in_pin(xtal), .crystal_out_pin(xout), .secondary_osc_enable(osc_en),
      .companion_8bit_timer_tick(tick), .companion_8bit_timer(comp), .cmp1_out(cmp1),
      .cmp2_out(cmp2), .cmp_gate_sync(cmp_sync), .overflow_flag(ovf), .count_value(cnt));
   // system clock, 20 ns
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // compare a value and count the outcome
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one cycle register write
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // one cycle register read, data checked in the following cycle
   task automatic rc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // count increments over a window after settling
   task automatic meas(input int n, input logic [15:0] exp);
      logic [15:0] c0;
      repeat (12) @(negedge clk);
      c0 = cnt;
      repeat (n) @(negedge clk);
      chk(cnt - c0, exp);
   endtask
   // expected gated count over a window of len system clocks
   function automatic logic [15:0] gate_exp(input logic [1:0] gs, input logic gl,
      input logic pol, input int len);
      int pulses;
      pulses = len / 256; // companion wraps once per 256 cycles
      if (gs == 2'h1) gate_exp = 16'(pol ? pulses : len - pulses);
      else gate_exp = (gl == pol) ? 16'(len) : 16'h0000;
   endfunction
   // verdict and end of run
   task automatic stop_test;
      if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      stop_test;
   end
   // main sequence
   initial begin
      logic [31:0] v;
      logic [1:0] cs, gs;
      logic gl, pol, x0;
      logic [15:0] base;
      int n;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) rc(a[2:0], 8'h00);
      v = $random(seed);
      wr(A_TC, v[7:0] & 8'hfe);
      rc(A_TC, v[7:0] & 8'hfe);
      chk({15'h0000, osc_en}, {15'h0000, v[3]});
      wr(A_GC, v[15:8] & 8'hdf);
      rc(A_GC, v[15:8] & 8'hdf & gst_pkg::GATE_CTRL_MASK);
      wr(A_TC, 8'h00);
      wr(A_GC, 8'h00);
      @(negedge clk);
      chk({15'h0000, xout}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         wr(A_HI, v[15:8]);
         wr(A_LO, v[7:0]);
         rc(A_LO, v[7:0]);
         rc(A_HI, v[15:8]);
      end
      // every source and prescale, stopped before each write
      for (int m = 0; m < 6; m++) begin
         for (int p = 0; p < 4; p++) begin
            cs = (m == 0) ? 2'h0 : (m == 1) ? 2'h1 : (m == 5) ? 2'h3 : 2'h2;
            n = ((m == 0) ? 4 : (m == 1) ? 1 : 6) << p;
            wr(A_TC, {cs, p[1:0], m == 4, m == 3, 2'b00});
            wr(A_LO, 8'h00);
            wr(A_TC, {cs, p[1:0], m == 4, m == 3, 2'b01});
            meas(n * 4, 16'h0004);
         end
      end
      wr(A_TC, 8'h40);
      meas(40, 16'h0000);
      // gate sources, polarities and levels
      wr(A_TC, 8'h41);
      for (int i = 0; i < 16; i++) begin
         {gl, pol, gs} = i[3:0];
         v = $random(seed);
         @(posedge clk);
         gate_level <= gl;
         cmp1 <= gl;
         cmp2 <= gl;
         cmp_sync <= v[0];
         wr(A_GC, {1'b1, pol, 4'h0, gs});
         meas(512, gate_exp(gs, gl, pol, 512));
      end
      // toggle mode against a short gate pulse train
      @(posedge clk);
      gate_per <= 8'h0a;
      wr(A_GC, 8'hc0);
      meas(80, 16'h0010);
      wr(A_GC, 8'he0);
      meas(80, 16'h0028);
      wr(A_GC, 8'hc0);
      meas(80, 16'h0010);
      wr(A_GC, 8'h00);
      // event counting waits for a falling edge
      ext_run <= 1'b0;
      wr(A_TC, 8'h80);
      wr(A_HI, 8'h00);
      wr(A_LO, 8'h00);
      wr(A_TC, 8'h81);
      repeat (10) @(posedge clk);
      ext_level <= 1'b1;
      repeat (16) @(negedge clk);
      chk(cnt, 16'h0000);
      @(posedge clk);
      ext_level <= 1'b0;
      repeat (10) @(posedge clk);
      ext_level <= 1'b1;
      repeat (16) @(negedge clk);
      chk(cnt, 16'h0001);
      // oscillator start-up wait by preset and overflow
      wr(A_TC, 8'h88);
      wr(A_ST, 8'h01);
      wr(A_HI, 8'hfc);
      wr(A_LO, 8'h00);
      wr(A_TC, 8'h89);
      @(negedge clk);
      x0 = xout;
      repeat (3) @(negedge clk);
      chk({15'h0000, xout ^ x0}, 16'h0001);
      repeat (6000) @(negedge clk);
      rc(A_ST, 8'h00);
      repeat (300) @(negedge clk);
      rc(A_ST, 8'h01);
      wr(A_ST, 8'h01);
      rc(A_ST, 8'h00);
      // wide access through the high byte buffer
      wr(A_TC, 8'h42);
      wr(A_HI, 8'h12);
      @(negedge clk);
      chk({8'h00, cnt[15:8]}, 16'h0000);
      wr(A_LO, 8'h34);
      @(negedge clk);
      chk(cnt, 16'h1234);
      rc(A_LO, 8'h34);
      rc(A_HI, 8'h12);
      wr(A_TC, 8'h43);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= A_LO;
      @(posedge clk);
      reg_addr <= A_HI;
      @(posedge clk);
      reg_rd <= 1'b0;
      // buffered high writes leave the prescaler and the count running
      wr(A_TC, 8'h73);
      repeat (12) @(negedge clk);
      base = cnt;
      repeat (16) wr(A_HI, 8'h56);
      @(negedge clk);
      chk(cnt - base, 16'h0004);
      repeat (4) @(posedge clk);
      stop_test;
   end
endmodule // gated_sixteen_bit_timer_tb
`default_nettype wire

// file: tb/gst_far_side.sv
// far side model: count clocks, gate pin and companion timer
`timescale 1ns/10ps
`default_nettype none
module gst_far_side (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_run,
   input wire logic ext_level,
   input wire logic [7:0] gate_per,
   input wire logic gate_level,
   output logic ext_pin,
   output logic lf_osc,
   output logic xtal,
   output logic gate_pin,
   output logic tick,
   output logic [7:0] comp_cnt
);
   logic [2:0] ph_reg; // six cycle clock phase
   logic [7:0] g_reg; // gate pulse phase
   // phase counters and a companion timer that wraps every 256 cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_reg <= 3'h0;
         g_reg <= 8'h00;
         comp_cnt <= 8'h00;
      end else begin
         ph_reg <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
         g_reg <= (g_reg + 8'h01 >= gate_per) ? 8'h00 : g_reg + 8'h01;
         comp_cnt <= comp_cnt + 8'h01;
      end
   end
   assign tick = !rst; // companion advances every cycle
   assign lf_osc = (ph_reg < 3'h3); // square wave, period six
   assign xtal = lf_osc;
   assign ext_pin = ext_run ? lf_osc : ext_level;
   assign gate_pin = (gate_per == 8'h00) ? gate_level : (g_reg < 8'h02); // short high pulse
endmodule // gst_far_side
`default_nettype wire

// file: tb/gst_timer_sva.sv
// checker: port level assertions for the gated timer
`timescale 1ns/10ps
`default_nettype none
module gst_timer_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic overflow_flag,
   input wire logic [15:0] count_value
);
   localparam logic [2:0] LO = gst_pkg::ADDR_COUNT_LOW;
   localparam logic [2:0] HI = gst_pkg::ADDR_COUNT_HIGH;
   logic [7:0] tc_reg; // shadow timer control
   logic gate_reg; // shadow gate enable
   logic ps_reg; // prescaler known clear
   logic cw; // count byte write
   logic clr; // overflow clear write
   logic free; // plain system clock counting
   assign cw = reg_wr && reg_addr <= HI;
   assign clr = reg_wr && reg_addr == gst_pkg::ADDR_STATUS && reg_wdata[0];
   assign free = tc_reg[7:4] == 4'h4 && tc_reg[0] && !gate_reg && ps_reg;
   // follow control writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tc_reg <= 8'h00;
         gate_reg <= 1'b0;
         ps_reg <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == gst_pkg::ADDR_TIMER_CTRL) tc_reg <= reg_wdata;
         if (reg_wr && reg_addr == gst_pkg::ADDR_GATE_CTRL) gate_reg <= reg_wdata[7];
         if (reg_wr && reg_addr == LO) ps_reg <= 1'b1;
         else if (reg_wr && reg_addr == gst_pkg::ADDR_TIMER_CTRL && reg_wdata[5:4] != tc_reg[5:4])
            ps_reg <= 1'b0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero when idle");
   off_hold_a: assert property (!tc_reg[0] && !cw |=> $stable(count_value))
      else $error("count moved while off");
   free_step_a: assert property (free && !cw
      |=> count_value == $past(count_value) + 16'h0001) else $error("count did not step");
   ovf_set_a: assert property (count_value == 16'hffff && !cw
      ##1 count_value == 16'h0000 |-> ##[0:1] overflow_flag)
      else $error("wrap did not set flag");
   flag_keep_a: assert property (overflow_flag && !clr |=> overflow_flag)
      else $error("flag dropped");
   flag_clear_a: assert property (clr && count_value != 16'hffff
      && $past(count_value) != 16'hffff |=> !overflow_flag) else $error("flag not cleared");
   low_read_a: assert property (reg_rd && reg_addr == LO
      |=> reg_rdata == 8'($past(count_value))) else $error("low byte read wrong");
   high_read_a: assert property (reg_rd && reg_addr == HI && !tc_reg[1]
      |=> reg_rdata == 8'($past(count_value) >> 8)) else $error("high byte read wrong");
   wide_read_a: assert property (reg_rd && reg_addr == LO && tc_reg[1]
      ##1 reg_rd && reg_addr == HI |=> reg_rdata == 8'($past(count_value, 2) >> 8))
      else $error("buffer not latched");
   wide_write_a: assert property (reg_wr && reg_addr == HI && tc_reg[1] && !tc_reg[0]
      |=> $stable(count_value)) else $error("buffered write reached count");
   low_write_a: assert property (reg_wr && reg_addr == LO && !tc_reg[1]
      |=> 8'(count_value) == $past(reg_wdata)) else $error("low write lost");
endmodule // gst_timer_sva
bind gst_timer gst_timer_sva chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .overflow_flag(overflow_flag), .count_value(count_value));
`default_nettype wire
